//--- src/timer_channel.sv
// one timer channel in interval / square-wave mode with ahb-lite registers
// assumes single ahb-lite master, zero-wait slave, word accesses only
//
// Overview of operation
// RULE1 - timer input goes synchroniser, optional filter, edge detector, then control
// RULE2 - filter off: input is only synchronised to the operating clock
// RULE3 - filter on: new level passes after two equal synchronised samples
// RULE4 - filter off: software waits two clocks after input-use bits set
// RULE5 - filter on: software waits four clocks after input-use bits set
// RULE6 - interrupt period is count clock period times reload data plus one
// RULE7 - channel output toggles on every interrupt giving fifty percent duty
// RULE8 - count register decrements once per count clock
// RULE9 - first count clock after start loads count from reload data
// RULE10 - start load raises interrupt and toggles output only with start-irq select
// RULE11 - at zero, next count clock raises interrupt, toggles, reloads
// RULE12 - reload data writable anytime, used only at next reload
// RULE13 - start trigger sets active flag, starts counting, reads back zero
// RULE14 - stop trigger clears active, count and output hold
// RULE15 - software must not change mode or output mode bits while running
// RULE16 - software sets output mode, level, default, then enables output
// RULE17 - with output disabled a write to output bit sets pin level
// RULE18 - unit disable stops clock, blocks writes, resets all, clears output
// RULE19 - mode bit 11 is master or split per channel, else fixed zero
// RULE20 - channels 1 and 3 pick from four prescaled clocks, others fewer
// RULE21 - start-irq select only acts in interval or capture mode
// RULE22 - count clock is a one-cycle enable in the operating clock domain
`timescale 1ns/1ps
`default_nettype none
module timer_channel
  import tmr_pkg::*;
#(
  parameter int unsigned CHAN = 0  // channel number 0..7
)(
  input  wire logic        hclk,      // operating clock
  input  wire logic        hresetn,   // async reset, active low
  input  wire logic        hsel,      // ahb slave select
  input  wire logic [31:0] haddr,     // ahb address
  input  wire logic [1:0]  htrans,    // ahb transfer type
  input  wire logic        hwrite,    // ahb write
  input  wire logic [2:0]  hsize,     // ahb size
  input  wire logic [31:0] hwdata,    // ahb write data
  input  wire logic        hready,    // ahb bus ready
  output logic [31:0]      hrdata,    // ahb read data
  output logic             hreadyout, // always ready
  output logic             hresp,     // always okay
  input  wire logic        tin_pin,   // timer_input_pin
  output logic             chan_output, // channel output level
  output logic             chan_irq   // interrupt pulse
);
  // channels 1 and 3 use four prescaled clocks, others only the first two
  localparam bit FOUR_CLK  = (CHAN == 1) || (CHAN == 3);
  localparam bit HAS_MSBIT = (CHAN >= 1) && (CHAN <= 4) || (CHAN == 6);

  logic        unit_power_enable_q;
  logic [15:0] chan_mode_reg_q;
  logic [15:0] reload_data_reg_q;
  logic [15:0] count_reg_q;
  logic        chan_active_flag_q;
  logic        load_pending_q;
  logic        out_bit_q;
  logic        output_enable_bit_q;
  logic        output_invert_bit_q;
  logic        output_slave_mode_bit_q;
  logic        nf_en_q;
  logic        irq_seen_q;
  logic [31:0] psc_q;

  // ahb-lite address phase capture
  logic        wr_q;
  logic        rd_q;
  logic [7:0]  addr_q;
  wire         take = hsel && hready && htrans[1];
  always_ff @(posedge hclk or negedge hresetn) begin
    if (!hresetn) begin
      wr_q   <= 1'b0;
      rd_q   <= 1'b0;
      addr_q <= 8'h00;
    end else begin
      wr_q   <= take && hwrite;
      rd_q   <= take && !hwrite;
      addr_q <= take ? haddr[7:0] : addr_q;
    end
  end
  wire clr = !unit_power_enable_q;

  // unit enable is always writable; everything else only when powered
  always_ff @(posedge hclk or negedge hresetn) begin
    if (!hresetn)
      unit_power_enable_q <= 1'b0;
    else if (wr_q && addr_q == OFS_UNIT)
      unit_power_enable_q <= hwdata[0];
  end
  wire wr_ok = wr_q && !clr; // [RULE18]

  logic [15:0] mode_wmask;
  always_comb begin
    mode_wmask = 16'hFFFF;
    if (!HAS_MSBIT)
      mode_wmask[MODE_MS_BIT] = 1'b0; // [RULE19]
    if (!FOUR_CLK)
      mode_wmask[MODE_CKS_LO+1] = 1'b0; // [RULE20]
  end

  always_ff @(posedge hclk or negedge hresetn) begin
    if (!hresetn) begin
      chan_mode_reg_q   <= MODE_RESET;
      reload_data_reg_q <= DATA_RESET;
      psc_q             <= PSC_RESET;
      nf_en_q           <= 1'b0;
    end else if (clr) begin
      chan_mode_reg_q   <= MODE_RESET; // [RULE18]
      reload_data_reg_q <= DATA_RESET;
      psc_q             <= PSC_RESET;
      nf_en_q           <= 1'b0;
    end else if (wr_ok) begin
      if (addr_q == OFS_MODE)
        chan_mode_reg_q <= hwdata[15:0] & mode_wmask;
      if (addr_q == OFS_DATA)
        reload_data_reg_q <= hwdata[15:0]; // [RULE12]
      if (addr_q == OFS_PSC)
        psc_q <= hwdata;
      if (addr_q == OFS_NF)
        nf_en_q <= hwdata[0];
    end
  end

  always_ff @(posedge hclk or negedge hresetn) begin
    if (!hresetn) begin
      output_enable_bit_q     <= 1'b0;
      output_invert_bit_q     <= 1'b0;
      output_slave_mode_bit_q <= 1'b0;
    end else if (clr) begin
      output_enable_bit_q     <= 1'b0;
      output_invert_bit_q     <= 1'b0;
      output_slave_mode_bit_q <= 1'b0;
    end else if (wr_ok && addr_q == OFS_OUT) begin
      output_enable_bit_q     <= hwdata[1];
      output_invert_bit_q     <= hwdata[2];
      output_slave_mode_bit_q <= hwdata[3];
    end
  end

  // count clock select among the prescaled clocks
  logic [3:0] ck_tick;
  genvar gi;
  generate
    for (gi = 0; gi < 4; gi++) begin : g_psc
      count_tick u_tick (
        .hclk    (hclk),
        .hresetn (hresetn),
        .clr     (clr),
        .div     (psc_q[gi*8 +: 8]),
        .tick    (ck_tick[gi])
      );
    end
  endgenerate
  wire [1:0] cks = chan_mode_reg_q[MODE_CKS_LO +: 2];

  tin_t tin;
  tin_cond u_tin (
    .hclk    (hclk),
    .hresetn (hresetn),
    .clr     (clr),
    .nf_en   (nf_en_q),
    .pin     (tin_pin),
    .tin     (tin)
  );
  // count source bit chooses input rising edges instead of the prescaler
  wire cnt_en = chan_mode_reg_q[MODE_CCS] ? tin.rise : ck_tick[cks]; // [RULE22]

  wire start_w = wr_ok && addr_q == OFS_TRIG && hwdata[0];
  wire stop_w  = wr_ok && addr_q == OFS_TRIG && hwdata[1];

  // channel active flag and the pending initial load
  always_ff @(posedge hclk or negedge hresetn) begin
    if (!hresetn) begin
      chan_active_flag_q <= 1'b0;
      load_pending_q     <= 1'b0;
    end else if (clr) begin
      chan_active_flag_q <= 1'b0;
      load_pending_q     <= 1'b0;
    end else if (stop_w) begin
      chan_active_flag_q <= 1'b0; // [RULE14]
      load_pending_q     <= 1'b0;
    end else if (start_w) begin
      chan_active_flag_q <= 1'b1; // [RULE13]
      load_pending_q     <= 1'b1;
    end else if (cnt_en)
      load_pending_q <= 1'b0;
  end

  wire run      = chan_active_flag_q && cnt_en;
  wire init_ld  = run && load_pending_q;
  wire wrap     = run && !load_pending_q && count_reg_q == 16'h0000;
  // start-irq select only matters in interval mode, the sole mode here
  wire evt      = wrap || (init_ld && chan_mode_reg_q[MODE_START_IRQ]);
  // [RULE10] [RULE21]

  always_ff @(posedge hclk or negedge hresetn) begin
    if (!hresetn)
      count_reg_q <= 16'h0000;
    else if (clr)
      count_reg_q <= 16'h0000;
    else if (init_ld || wrap)
      count_reg_q <= reload_data_reg_q; // [RULE9] [RULE11] [RULE6]
    else if (run)
      count_reg_q <= count_reg_q - 16'h0001; // [RULE8]
  end

  always_ff @(posedge hclk or negedge hresetn) begin
    if (!hresetn)
      chan_irq <= 1'b0;
    else
      chan_irq <= evt && !clr; // [RULE6] [RULE11]
  end

  // output bit: toggles when enabled, written by software when disabled
  always_ff @(posedge hclk or negedge hresetn) begin
    if (!hresetn)
      out_bit_q <= 1'b0;
    else if (clr)
      out_bit_q <= 1'b0; // [RULE18]
    else if (output_enable_bit_q) begin
      if (evt)
        out_bit_q <= ~out_bit_q; // [RULE7]
    end else if (wr_ok && addr_q == OFS_OUT)
      out_bit_q <= hwdata[0]; // [RULE17]
  end
  // pin follows the bit; the stopped channel makes no toggles
  always_ff @(posedge hclk or negedge hresetn) begin
    if (!hresetn)
      chan_output <= 1'b0;
    else if (clr)
      chan_output <= 1'b0;
    else if (output_enable_bit_q && evt)
      chan_output <= ~out_bit_q; // [RULE7]
    else if (!output_enable_bit_q && wr_ok && addr_q == OFS_OUT)
      chan_output <= hwdata[0]; // [RULE17]
    else
      chan_output <= out_bit_q;
  end

  // sticky record of an interrupt, cleared by writing 1; set wins
  always_ff @(posedge hclk or negedge hresetn) begin
    if (!hresetn)
      irq_seen_q <= 1'b0;
    else if (clr)
      irq_seen_q <= 1'b0;
    else if (evt)
      irq_seen_q <= 1'b1;
    else if (wr_ok && addr_q == OFS_STAT && hwdata[1])
      irq_seen_q <= 1'b0;
  end

  // read data decoded in the address phase and registered
  logic [31:0] rd_d;
  always_comb begin
    rd_d = 32'h0000_0000;
    case (haddr[7:0])
      OFS_UNIT:  rd_d[0]     = unit_power_enable_q;
      OFS_MODE:  rd_d[15:0]  = chan_mode_reg_q;
      OFS_TRIG:  rd_d        = 32'h0000_0000; // [RULE13]
      OFS_STAT:  rd_d[1:0]   = {irq_seen_q, chan_active_flag_q};
      OFS_DATA:  rd_d[15:0]  = reload_data_reg_q;
      OFS_COUNT: rd_d[15:0]  = count_reg_q;
      OFS_OUT:   rd_d[3:0]   = {output_slave_mode_bit_q, output_invert_bit_q,
                                output_enable_bit_q, out_bit_q};
      OFS_PSC:   rd_d        = psc_q;
      OFS_NF:    rd_d[0]     = nf_en_q;
      OFS_INPUT: rd_d[1:0]   = {tin.rise, tin.level};
      default:   rd_d        = 32'h0000_0000;
    endcase
  end
  always_ff @(posedge hclk or negedge hresetn) begin
    if (!hresetn)
      hrdata <= 32'h0000_0000;
    else if (take && !hwrite)
      hrdata <= rd_d;
  end
  always_ff @(posedge hclk or negedge hresetn) begin
    if (!hresetn) begin
      hreadyout <= 1'b1;
      hresp     <= 1'b0;
    end else begin
      hreadyout <= 1'b1;
      hresp     <= 1'b0;
    end
  end
endmodule : timer_channel
`default_nettype wire

//--- src/tmr_pkg.sv
// package for one interval/square-wave timer channel behind an ahb-lite slave
// assumes a single 100 MHz clock and word-aligned 32-bit register access
package tmr_pkg;
  localparam int unsigned DATA_W = 16;
  // register byte offsets
  localparam logic [7:0] OFS_UNIT  = 8'h00; // bit0 unit_power_enable
  localparam logic [7:0] OFS_MODE  = 8'h04; // chan_mode_reg
  localparam logic [7:0] OFS_TRIG  = 8'h08; // bit0 start, bit1 stop (w1)
  localparam logic [7:0] OFS_STAT  = 8'h0C; // bit0 active, bit1 irq seen
  localparam logic [7:0] OFS_DATA  = 8'h10; // reload_data_reg
  localparam logic [7:0] OFS_COUNT = 8'h14; // count_reg (ro)
  localparam logic [7:0] OFS_OUT   = 8'h18; // bit0 chan_output,1 oe,2 inv,3 sl
  localparam logic [7:0] OFS_PSC   = 8'h1C; // prescaler divisors, 4 x 8 bit
  localparam logic [7:0] OFS_NF    = 8'h20; // bit0 noise filter enable
  localparam logic [7:0] OFS_INPUT = 8'h24; // bit0 filtered level, bit1 edge
  // mode register fields
  localparam int unsigned MODE_START_IRQ = 0;  // start_irq_select
  localparam int unsigned MODE_STS_LO    = 8;  // start_source_sel_lo
  localparam int unsigned MODE_STS_HI    = 9;  // start_source_sel_hi
  localparam int unsigned MODE_MS_BIT    = 11; // master/split bit
  localparam int unsigned MODE_CCS       = 12; // count_source_select
  localparam int unsigned MODE_CKS_LO    = 14; // prescaled clock select
  localparam logic [15:0] MODE_RESET     = 16'h0000;
  localparam logic [15:0] DATA_RESET     = 16'hFFFF;
  localparam logic [31:0] PSC_RESET      = 32'h0000_0000;
  localparam int unsigned FILTER_SAMPLES = 2;
  typedef struct packed {
    logic level;
    logic rise;
    logic fall;
  } tin_t;
endpackage : tmr_pkg

//--- src/tin_cond.sv
// timer input conditioning: synchroniser, optional filter, edge detector
// assumes the pin is asynchronous; output lives in hclk domain
`timescale 1ns/1ps
`default_nettype none
module tin_cond
  import tmr_pkg::*;
(
  input  wire logic hclk,     // operating clock
  input  wire logic hresetn,  // async reset, active low
  input  wire logic clr,      // unit disabled: hold filter and edge state in reset
  input  wire logic nf_en,    // noise filter enable
  input  wire logic pin,      // timer_input_pin
  output tin_t      tin       // conditioned level and edges
);
  logic s1_q, s2_q, s3_q, lvl_q;
  always_ff @(posedge hclk or negedge hresetn) begin
    if (!hresetn) begin
      s1_q <= 1'b0;
      s2_q <= 1'b0;
    end else begin
      s1_q <= pin; // [RULE1]
      s2_q <= s1_q;
    end
  end
  // filter history: s2 must match s3, two equal samples, before it passes
  always_ff @(posedge hclk or negedge hresetn) begin
    if (!hresetn) begin
      s3_q  <= 1'b0;
      lvl_q <= 1'b0;
    end else if (clr) begin
      s3_q  <= 1'b0;
      lvl_q <= 1'b0;
    end else begin
      s3_q <= s2_q;
      if (!nf_en)
        lvl_q <= s2_q;            // [RULE2]
      else if (s2_q == s3_q)
        lvl_q <= s2_q;            // [RULE3]
    end
  end
  logic prev_q;
  always_ff @(posedge hclk or negedge hresetn) begin
    if (!hresetn)
      prev_q <= 1'b0;
    else if (clr)
      prev_q <= 1'b0;
    else
      prev_q <= lvl_q;
  end
  assign tin.level = lvl_q;
  assign tin.rise  = lvl_q & ~prev_q; // [RULE1]
  assign tin.fall  = ~lvl_q & prev_q;
endmodule : tin_cond
`default_nettype wire

//--- src/count_tick.sv
// prescaler that makes the count clock as a one-cycle enable
// assumes divisor 0 means every operating clock edge
`timescale 1ns/1ps
`default_nettype none
module count_tick
  import tmr_pkg::*;
(
  input  wire logic       hclk,    // operating clock
  input  wire logic       hresetn, // async reset, active low
  input  wire logic       clr,     // unit disabled
  input  wire logic [7:0] div,     // cycles between ticks minus one
  output logic            tick     // count clock enable pulse
);
  logic [7:0] cnt_q;
  always_ff @(posedge hclk or negedge hresetn) begin
    if (!hresetn)
      cnt_q <= 8'h00;
    else if (clr || cnt_q >= div)
      cnt_q <= 8'h00;
    else
      cnt_q <= cnt_q + 8'h01;
  end
  assign tick = !clr && (cnt_q >= div); // [RULE22]
endmodule : count_tick
`default_nettype wire

//--- dv/timer_channel_sva.sv
// assertion checker for one timer channel, watching its top ports only
// assumes hready is the slave's own hreadyout (single slave bus)
`timescale 1ns/1ps
`default_nettype none
module timer_channel_sva
  import tmr_pkg::*;
#(
  parameter int unsigned CHAN = 0  // channel number
)(
  input wire logic        hclk,        // operating clock
  input wire logic        hresetn,     // async reset, active low
  input wire logic        hsel,        // slave select
  input wire logic [31:0] haddr,       // address
  input wire logic [1:0]  htrans,      // transfer type
  input wire logic        hwrite,      // write
  input wire logic [2:0]  hsize,       // size
  input wire logic [31:0] hwdata,      // write data
  input wire logic        hready,      // bus ready
  input wire logic [31:0] hrdata,      // read data
  input wire logic        hreadyout,   // slave ready
  input wire logic        hresp,       // response
  input wire logic        tin_pin,     // timer input
  input wire logic        chan_output, // channel output
  input wire logic        chan_irq     // interrupt pulse
);
  logic       rd_q;
  logic       wr_unit_q;
  logic [7:0] ofs_q;
  logic       aph;
  // only the low byte decodes; upper address bits must be zero
  assign aph = hsel && hready && htrans[1] && haddr[31:8] == 24'h00_0000;
  always_ff @(posedge hclk or negedge hresetn) begin
    if (!hresetn) begin
      rd_q      <= 1'b0;
      wr_unit_q <= 1'b0;
      ofs_q     <= 8'h00;
    end else begin
      rd_q      <= aph && !hwrite;
      wr_unit_q <= aph && hwrite && haddr[7:0] == OFS_UNIT;
      ofs_q     <= haddr[7:0];
    end
  end
  default clocking cb @(posedge hclk); endclocking
  default disable iff (!hresetn);
  AST_READY: assert property (hreadyout)
    else $error("slave inserted a wait state");
  AST_OKAY: assert property (!hresp)
    else $error("slave gave an error response");
  AST_RDATA_HOLD: assert property (!rd_q |-> $stable(hrdata))
    else $error("read data moved outside a read");
  AST_TRIG_RD0: assert property (
    rd_q && ofs_q == OFS_TRIG |-> hrdata == 32'h0000_0000)
    else $error("trigger bits did not read back zero");
  AST_HOLE_RD0: assert property (
    rd_q && ofs_q > OFS_INPUT && ofs_q[1:0] == 2'b00 |-> hrdata == '0)
    else $error("unmapped read not zero");
  AST_MS_FIXED: assert property (
    rd_q && ofs_q == OFS_MODE && (CHAN == 0 || CHAN == 5 || CHAN == 7)
    |-> !hrdata[MODE_MS_BIT]) else $error("master/split bit not fixed");
  AST_CKS_FIXED: assert property (
    rd_q && ofs_q == OFS_MODE && CHAN != 1 && CHAN != 3
    |-> !hrdata[15] && hrdata[31:16] == 16'h0000)
    else $error("clock select high bit not fixed");
  AST_UNIT_OFF: assert property (
    wr_unit_q && !hwdata[0] |-> ##2 !chan_output [*2])
    else $error("output not cleared by unit disable");
  AST_OUT_WIDTH: assert property (
    rd_q && ofs_q == OFS_OUT |-> hrdata[31:4] == 28'h000_0000)
    else $error("output register unused bits set");
endmodule : timer_channel_sva

bind timer_channel timer_channel_sva #(.CHAN(CHAN)) u_timer_channel_sva (
  .hclk(hclk), .hresetn(hresetn), .hsel(hsel), .haddr(haddr),
  .htrans(htrans), .hwrite(hwrite), .hsize(hsize), .hwdata(hwdata),
  .hready(hready), .hrdata(hrdata), .hreadyout(hreadyout), .hresp(hresp),
  .tin_pin(tin_pin), .chan_output(chan_output), .chan_irq(chan_irq));
`default_nettype wire

//--- dv/tin_source.sv
// model of the external signal source on the timer input pin
// assumes an idle-low pin; the bench places pulses against its clock
`timescale 1ns/1ps
`default_nettype none
module tin_source (
  output var logic pin  // timer input level
);
  initial pin = 1'b0;
  // asynchronous to the operating clock, as a real source would be
  task pulse(input int hi_ns);
    pin = 1'b1;
    #(hi_ns);
    pin = 1'b0;
  endtask : pulse
endmodule : tin_source
`default_nettype wire

//--- dv/timer_channel_tb.sv
// self-checking bench for one interval/square-wave timer channel
// assumes the ahb-lite master here and the input source model
`timescale 1ns/1ps
`default_nettype none
module timer_channel_tb
  import tmr_pkg::*;
;
  logic        hclk = 1'b0;
  logic        hresetn = 1'b0;
  logic        hsel = 1'b0;
  logic        hwrite = 1'b0;
  logic [1:0]  htrans = 2'b00;
  logic [2:0]  hsize = 3'b010;
  logic [31:0] haddr = 32'h0000_0000;
  logic [31:0] hwdata = 32'h0000_0000;
  logic [31:0] hrdata;
  logic        hreadyout, hresp, tin_pin, chan_output, chan_irq, last_o;
  int          err_count = 0;
  int          n_checks = 0;
  int          cyc = 0;
  always #5 hclk = ~hclk;
  timer_channel #(.CHAN(0)) u_timer_channel (
    .hclk(hclk), .hresetn(hresetn), .hsel(hsel), .haddr(haddr),
    .htrans(htrans), .hwrite(hwrite), .hsize(hsize), .hwdata(hwdata),
    .hready(hreadyout), .hrdata(hrdata), .hreadyout(hreadyout),
    .hresp(hresp), .tin_pin(tin_pin), .chan_output(chan_output),
    .chan_irq(chan_irq));
  tin_source u_tin_source (.pin(tin_pin));
  task end_of_test;
    $display("checks %0d mismatches %0d", n_checks, err_count);
    if (err_count == 0 && n_checks > 0)
      $display("All checks passed");
    else
      $display("Checks failed");
    $finish;
  endtask : end_of_test
  always @(posedge hclk) begin
    cyc <= cyc + 1;
    if (cyc == 5000) begin
      err_count++;
      end_of_test();
    end
  end
  task chk(input string name, input logic [31:0] exp, input logic [31:0] got);
    n_checks++;
    if (got !== exp) begin
      err_count++;
      $display("mismatch %s expected %h seen %h", name, exp, got);
    end
  endtask : chk
  // entered just after a rising edge; read data taken at the closing edge
  task ahb(input logic w, input logic [7:0] a, input logic [31:0] d,
           output logic [31:0] r);
    hsel <= 1'b1;
    htrans <= 2'b10;
    haddr <= {24'h00_0000, a};
    hwrite <= w;
    do @(posedge hclk); while (hreadyout !== 1'b1);
    htrans <= 2'b00;
    hwdata <= d;
    do @(posedge hclk); while (hreadyout !== 1'b1);
    r = hrdata;
  endtask : ahb
  task wr(input logic [7:0] a, input logic [31:0] d);
    logic [31:0] r;
    ahb(1'b1, a, d, r);
  endtask : wr
  task rdchk(input string name, input logic [7:0] a, input logic [31:0] e);
    logic [31:0] r;
    ahb(1'b0, a, 32'h0000_0000, r);
    chk(name, e, r);
  endtask : rdchk
  // counts edges to the next interrupt; with cmp set, output must flip between calls
  task wait_irq(input logic cmp, output int n);
    n = 0;
    do begin
      @(posedge hclk);
      n++;
    end while (chan_irq !== 1'b1 && n < 100);
    if (cmp) chk("toggle", !last_o, chan_output);
    last_o = chan_output;
  endtask : wait_irq
  task t_reset;
    rdchk("data", OFS_DATA, {16'h0000, DATA_RESET});
    wr(OFS_DATA, 16'h0005);
    rdchk("blocked", OFS_DATA, {16'h0000, DATA_RESET});
    rdchk("hole", 8'h40, 32'h0000_0000);
    wr(OFS_UNIT, 16'h0001);
    wr(OFS_MODE, 16'h8801);
    rdchk("mode", OFS_MODE, 16'h0001);
    $display("test reset done");
  endtask : t_reset
  task t_interval(input logic sirq);
    int          n;
    logic [31:0] r;
    logic        o;
    wr(OFS_PSC, 16'h0001);
    wr(OFS_MODE, {15'h0000, sirq});
    wr(OFS_DATA, 16'h0003);
    wr(OFS_OUT, 16'h0000);
    wr(OFS_OUT, 16'h0002);
    chk("oe stopped", 1'b0, chan_output);
    wr(OFS_TRIG, 16'h0001);
    wait_irq(1'b0, n);
    chk("start irq", sirq, n < 8);
    wait_irq(1'b1, n);
    chk("gap", 8'h08, n);
    wr(OFS_DATA, 16'h0005);
    wait_irq(1'b1, n);
    chk("old gap", 8'h08, n + 2);
    wait_irq(1'b1, n);
    chk("new gap", 8'h0C, n);
    rdchk("trig", OFS_TRIG, 32'h0000_0000);
    ahb(1'b0, OFS_STAT, 32'h0000_0000, r);
    chk("active", 1'b1, r[0]);
    o = chan_output;
    wr(OFS_TRIG, 16'h0002);
    ahb(1'b0, OFS_COUNT, 32'h0000_0000, r);
    repeat (20) @(posedge hclk);
    rdchk("count held", OFS_COUNT, r);
    ahb(1'b0, OFS_STAT, 32'h0000_0000, r);
    chk("stopped", 1'b0, r[0]);
    chk("out held", o, chan_output);
    $display("test interval done");
  endtask : t_interval
  task t_out;
    // the output bit is only writable once the enable is already clear
    wr(OFS_OUT, 16'h0000);
    wr(OFS_OUT, 16'h0001);
    @(posedge hclk);
    chk("sw out", 1'b1, chan_output);
    wr(OFS_UNIT, 16'h0000);
    repeat (2) @(posedge hclk);
    chk("off out", 1'b0, chan_output);
    wr(OFS_UNIT, 16'h0001);
    rdchk("out reg", OFS_OUT, 32'h0000_0000);
    rdchk("data init", OFS_DATA, {16'h0000, DATA_RESET});
    $display("test output done");
  endtask : t_out
  // a short pulse covers exactly one rising edge of the operating clock
  task t_input(input logic nf, input logic [31:0] e);
    wr(OFS_NF, {15'h0000, nf});
    wr(OFS_MODE, 16'h1000);
    repeat (4) @(posedge hclk);
    wr(OFS_DATA, 16'h0064);
    wr(OFS_TRIG, 16'h0001);
    u_tin_source.pulse(50);
    repeat (10) @(posedge hclk);
    rdchk("load", OFS_COUNT, 16'h0064);
    #8;
    u_tin_source.pulse(5);
    repeat (10) @(posedge hclk);
    rdchk("glitch", OFS_COUNT, e);
    u_tin_source.pulse(50);
    repeat (10) @(posedge hclk);
    rdchk("edge", OFS_COUNT, e - 1);
    wr(OFS_TRIG, 16'h0002);
    $display("test input done");
  endtask : t_input
  initial begin
    repeat (4) @(posedge hclk);
    hresetn <= 1'b1;
    t_reset();
    t_interval(1'b0);
    t_interval(1'b1);
    t_out();
    t_input(1'b0, 16'h0063);
    t_input(1'b1, 16'h0064);
    end_of_test();
  end
endmodule : timer_channel_tb
`default_nettype wire
